/* File: hw/tpa_defs.vh */
// constants for the tag page access command handler
`ifndef TPA_DEFS_VH
`define TPA_DEFS_VH
// opcodes in the high nibble of the first frame byte
`define TPA_OP_READ 4'h4
`define TPA_OP_WRITE 4'h3
`define TPA_OP_LOCK 4'h2
// frame layout: opcode, address, eight data bytes, two checksum bytes
`define TPA_FRAME_LEN 4'hc
`define TPA_CNT_OVER 4'hd
`define TPA_IDX_OP 4'h0
`define TPA_IDX_ADDR 4'h1
`define TPA_IDX_DATA0 4'h2
`define TPA_IDX_DATA7 4'h9
// checksum
`define TPA_CRC_POLY 16'h1021
`define TPA_CRC_INIT 16'hffff
`define TPA_CRC_GOOD 16'h0000
// pages with special meaning
`define TPA_PG_SERIAL 5'h00
`define TPA_PG_SIG 5'h02
`define TPA_PG_PWD 5'h03
`define TPA_PG_OPEN_MAX 5'h02
// write-protect field sits in page 0, bits 62..32, field bit n at page bit 32+n
`define TPA_LOCK_LSB 32
`define TPA_LOCK_MSB 62
`define TPA_LOCK_W 31
`define TPA_LOCK_SKIP 33
// answer kinds
`define TPA_RESP_ACK 2'h1
`define TPA_RESP_NACK 2'h2
`define TPA_RESP_DATA 2'h3
// programming time: strictly below the longest allowed wait
`define TPA_WR_TIME_NS 3000000
`define TPA_CLK_NS 10
`define TPA_WR_CYCLES ((`TPA_WR_TIME_NS / `TPA_CLK_NS) - 1)
`endif

/* File: hw/tpa_top.v */
// tag page access command handler with its receive byte fifo
`default_nettype none
`include "tpa_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// byte fifo between the frame receiver and the command handler
module tpa_fifo #(
  parameter DW = 9,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [DW-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [DW-1:0] out_data
);
  reg [DW-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  // full and empty come straight from the fill count
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage has no reset; only pointers and fill count need a defined state
  always @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers wrap naturally since depth is a power of two
  always @(posedge clk) begin
    if (rst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // tpa_fifo

////////////////////////////////////////////////////////////////////////////////
module tpa_top #(
  parameter WR_CYCLES = `TPA_WR_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire rx_valid,
  output wire rx_ready,
  input wire [7:0] rx_byte,
  input wire rx_last,
  input wire tag_active,
  input wire [3:0] card_slot_identifier,
  input wire pwd_open_set,
  input wire pwd_open_clr,
  output wire pwd_open,
  output wire busy,
  output wire resp_valid,
  input wire resp_ready,
  output wire [1:0] resp_kind,
  output wire [63:0] resp_data
);
  localparam [3:0] S_RX = 4'h1;
  localparam [3:0] S_CHK = 4'h2;
  localparam [3:0] S_PROG = 4'h4;
  localparam [3:0] S_RESP = 4'h8;

  // one checksum step per byte, bits taken lsb first
  function [15:0] crc_byte;
    input [15:0] crc;
    input [7:0] b;
    integer i;
    reg [15:0] c;
    reg fb;
    begin
      c = crc;
      for (i = 0; i < 8; i = i + 1) begin
        fb = c[15] ^ b[i];
        c = {c[14:0], 1'b0} ^ (fb ? `TPA_CRC_POLY : 16'h0000);
      end
      crc_byte = c;
    end
  endfunction

  // opcode decode, one-hot {lock, write, read}; shared by legality check and dispatch
  function [2:0] op_decode;
    input [3:0] op;
    begin
      case (op)
        `TPA_OP_READ: op_decode = 3'h1;
        `TPA_OP_WRITE: op_decode = 3'h2;
        `TPA_OP_LOCK: op_decode = 3'h4;
        default: op_decode = 3'h0; // other opcodes decode to zero, so the frame is dropped unanswered
      endcase
    end
  endfunction

  reg [63:0] mem_q [0:31];
  reg [3:0] state_q;
  reg [3:0] cnt_q;
  reg [15:0] crc_q;
  reg [7:0] op_q;
  reg [4:0] page_q;
  reg [63:0] data_q;
  reg pwd_q;
  reg is_lock_q;
  reg [1:0] kind_q;
  reg [63:0] rdata_q;
  reg [18:0] prog_q;
  wire [8:0] f_data;
  wire f_valid;
  wire pop;
  wire [3:0] opc;
  wire [2:0] op_sel;
  wire frame_ok;
  wire [30:0] prot;
  wire page_locked;
  integer k;

  // factory state: every page, and so the protect field, is all zeros
  initial begin
    for (k = 0; k < 32; k = k + 1) mem_q[k] = 64'h0000000000000000;
  end

  // fifo lets the receiver hand over up to eight bytes while a page is programming
  tpa_fifo #(
    .DW(9),
    .DEPTH(8),
    .AW(3)
  ) tpa_fifo_inst (
    .clk(clk),
    .rst(rst),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data({rx_last, rx_byte}),
    .out_valid(f_valid),
    .out_ready(state_q == S_RX),
    .out_data(f_data)
  );

  assign pop = f_valid & (state_q == S_RX);
  assign opc = op_q[7:4];
  assign op_sel = op_decode(opc);
  assign prot = mem_q[`TPA_PG_SERIAL][`TPA_LOCK_MSB:`TPA_LOCK_LSB];
  // page 31 has no protect bit and so can never be locked
  assign page_locked = (page_q != 5'h1f) && prot[page_q];

  // legality: length, checksum, state, slot identifier, known opcode
  assign frame_ok = (cnt_q == `TPA_FRAME_LEN) &&
                    (crc_q == `TPA_CRC_GOOD) &&
                    tag_active &&
                    (op_q[3:0] == card_slot_identifier) &&
                    (op_sel != 3'h0);

  // pwd_open, resp_kind and resp_data come straight from registers; busy and resp_valid are decoded from state_q
  assign pwd_open = pwd_q;
  assign busy = (state_q == S_PROG);
  assign resp_valid = (state_q == S_RESP);
  assign resp_kind = kind_q;
  assign resp_data = rdata_q;

  // password flag: closed at reset, an opening event wins over a close
  always @(posedge clk) begin
    if (rst) pwd_q <= 1'b0;
    else if (pwd_open_set) pwd_q <= 1'b1;
    else if (pwd_open_clr) pwd_q <= 1'b0;
  end

  // memory is touched only at the end of an accepted programming cycle
  always @(posedge clk) begin
    if (state_q == S_PROG && prog_q == 19'h00000) begin
      if (is_lock_q) begin
        // bits can only be added, never removed
        mem_q[`TPA_PG_SERIAL][`TPA_LOCK_MSB:`TPA_LOCK_LSB] <=
          prot | data_q[63:`TPA_LOCK_SKIP];
      end else begin
        mem_q[page_q] <= data_q;
      end
    end
  end

  // frame collection, decision, programming wait and answer
  always @(posedge clk) begin
    if (rst) begin
      state_q <= S_RX;
      cnt_q <= 4'h0;
      crc_q <= `TPA_CRC_INIT;
      op_q <= 8'h00;
      page_q <= 5'h00;
      data_q <= 64'h0000000000000000;
      is_lock_q <= 1'b0;
      kind_q <= 2'h0;
      rdata_q <= 64'h0000000000000000;
      prog_q <= 19'h00000;
    end else begin
      case (state_q)
        S_RX: begin
          if (pop) begin
            crc_q <= crc_byte(crc_q, f_data[7:0]);
            if (cnt_q != `TPA_CNT_OVER) cnt_q <= cnt_q + 4'h1;
            if (cnt_q == `TPA_IDX_OP) op_q <= f_data[7:0];
            if (cnt_q == `TPA_IDX_ADDR) page_q <= f_data[4:0];
            // first data byte ends up in the low byte of the page
            if (cnt_q >= `TPA_IDX_DATA0 && cnt_q <= `TPA_IDX_DATA7) begin
              data_q <= {f_data[7:0], data_q[63:8]};
            end
            if (f_data[8]) state_q <= S_CHK;
          end
        end
        S_CHK: begin
          // counters re-armed here so the next frame starts clean even after a reject
          cnt_q <= 4'h0;
          crc_q <= `TPA_CRC_INIT;
          is_lock_q <= op_sel[2];
          prog_q <= WR_CYCLES[18:0];
          rdata_q <= 64'h0000000000000000;
          if (!frame_ok) begin
            state_q <= S_RX;
          end else if (op_sel[0]) begin
            state_q <= S_RESP;
            if (page_q == `TPA_PG_PWD) begin
              kind_q <= `TPA_RESP_NACK;
            end else if (page_q > `TPA_PG_OPEN_MAX && !pwd_q) begin
              kind_q <= `TPA_RESP_NACK;
            end else begin
              // lock state plays no part in reads
              kind_q <= `TPA_RESP_DATA;
              rdata_q <= mem_q[page_q];
            end
          end else if (op_sel[1]) begin
            if (page_q == `TPA_PG_SERIAL || page_q == `TPA_PG_SIG) begin
              kind_q <= `TPA_RESP_NACK;
              state_q <= S_RESP;
            end else if (!pwd_q || page_locked) begin
              kind_q <= `TPA_RESP_NACK;
              state_q <= S_RESP;
            end else begin
              state_q <= S_PROG;
            end
          end else if (!pwd_q) begin
            kind_q <= `TPA_RESP_NACK;
            state_q <= S_RESP;
          end else begin
            state_q <= S_PROG;
          end
        end
        S_PROG: begin
          // the ack waits for the full programming time
          if (prog_q == 19'h00000) begin
            kind_q <= `TPA_RESP_ACK;
            state_q <= S_RESP;
          end else begin
            prog_q <= prog_q - 19'h00001;
          end
        end
        S_RESP: begin
          if (resp_ready) state_q <= S_RX;
        end
        default: begin
          state_q <= S_RX;
        end
      endcase
    end
  end
endmodule // tpa_top
`default_nettype wire

/* File: tb/tpa_props.sv */
// assertions for the tag page access command handler
`default_nettype none
module tpa_checker #(
  parameter int WR_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic busy,
  input wire logic resp_valid,
  input wire logic resp_ready,
  input wire logic [1:0] resp_kind,
  input wire logic [63:0] resp_data,
  input wire logic pwd_open_set,
  input wire logic pwd_open_clr,
  input wire logic pwd_open
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] bcnt_q;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // counts busy cycles; a counter since the wait is far beyond a repetition
  always @(posedge clk) bcnt_q <= (rst || !busy) ? 32'h0 : bcnt_q + 32'h1;
  chk_busy_quiet: assert property (busy |-> !resp_valid) else $error("answer while busy");
  chk_resp_hold: assert property (resp_valid && !resp_ready |=>
    resp_valid && $stable(resp_kind) && $stable(resp_data)) else $error("answer not held");
  chk_ack_late: assert property ($rose(resp_valid) && resp_kind == 2'h1 |-> $past(busy))
    else $error("ack without programming");
  chk_busy_len: assert property ($fell(busy) |-> bcnt_q == WR_CYCLES + 1)
    else $error("wrong programming time");
  chk_nack_nowr: assert property ($rose(resp_valid) && resp_kind == 2'h2 |-> !$past(busy))
    else $error("nack after programming");
  chk_prog_pwd: assert property ($rose(busy) |-> pwd_open)
    else $error("programming without password");
  chk_pwd_set: assert property (pwd_open_set |=> pwd_open) else $error("flag not set");
  chk_pwd_clr: assert property (pwd_open_clr && !pwd_open_set |=> !pwd_open)
    else $error("flag not cleared");
  cov_data: cover property ($rose(resp_valid) && resp_kind == 2'h3);
  cov_ack: cover property ($rose(resp_valid) && resp_kind == 2'h1);
  cov_nack: cover property ($rose(resp_valid) && resp_kind == 2'h2);
endmodule // tpa_checker
bind tpa_top tpa_checker #(.WR_CYCLES(WR_CYCLES)) tpa_checker_inst (.clk(clk), .rst(rst),
  .busy(busy), .resp_valid(resp_valid), .resp_ready(resp_ready), .resp_kind(resp_kind),
  .resp_data(resp_data), .pwd_open_set(pwd_open_set), .pwd_open_clr(pwd_open_clr),
  .pwd_open(pwd_open));
`default_nettype wire

/* File: tb/tpa_reader_model.sv */
// reader_writer model: sends framed commands and takes answers
`default_nettype none
module tpa_reader_model (
  input wire logic clk,
  input wire logic rx_ready,
  output logic rx_valid = 1'b0,
  output logic [7:0] rx_byte = 8'h00,
  output logic rx_last = 1'b0,
  input wire logic resp_valid,
  output logic resp_ready = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // one frame; bad flips a checksum bit; returns only once every byte is taken
  task automatic send(input logic [3:0] op, input logic [3:0] slot, input logic [7:0] addr,
                      input logic [63:0] data, input logic bad);
    logic [7:0] fr [12];
    logic [15:0] crc;
    crc = 16'hffff;
    fr[0] = {op, slot};
    fr[1] = addr;
    for (int i = 0; i < 8; i++) fr[2 + i] = data[8 * i +: 8];
    for (int i = 0; i < 80; i++) begin
      crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ fr[i / 8][i % 8]) ? 16'h1021 : 16'h0000);
    end
    fr[10] = {<<{crc[15:8]}};
    fr[11] = {<<{crc[7:0]}};
    fr[10][0] = fr[10][0] ^ bad;
    for (int i = 0; i < 12; i++) begin
      rx_valid = 1'b1;
      rx_byte = fr[i];
      rx_last = (i == 11);
      while (rx_ready !== 1'b1) begin
        @(posedge clk);
        #1;
      end
      @(posedge clk);
      #1;
    end
    // released byte lines show the inverse rather than a stale value
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;
    rx_last = 1'b0;
  endtask
  // waits for an answer, stalls a while, then takes it; stays quiet meanwhile
  task automatic take(input int stall);
    int n;
    n = 0;
    while (resp_valid !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    repeat (stall) begin
      @(posedge clk);
      #1;
    end
    resp_ready = 1'b1;
    @(posedge clk);
    #1;
    resp_ready = 1'b0;
  endtask
endmodule // tpa_reader_model
`default_nettype wire

/* File: tb/tag_page_access_commands_bench.sv */
// self-checking bench for the tag page access command handler
`default_nettype none
`define CHK(nm, e, g) check(nm, 64'(e), 64'(g))
module tag_page_access_commands_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, tag_active = 1'b1, pwd_open_set = 1'b0, pwd_open_clr = 1'b0;
  logic rx_valid, rx_ready, rx_last, resp_valid, resp_ready, pwd_open, busy;
  logic [7:0] rx_byte;
  logic [3:0] slot = 4'h9;
  logic [1:0] resp_kind;
  logic [63:0] resp_data;
  int failures = 0, comparisons = 0;
  localparam logic [63:0] D = 64'h0123_4567_89ab_cdef;
  always #5 clk = ~clk;
  tpa_top #(.WR_CYCLES(20)) tpa_top_inst (.clk(clk), .rst(rst), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_byte(rx_byte), .rx_last(rx_last), .tag_active(tag_active),
    .card_slot_identifier(slot), .pwd_open_set(pwd_open_set), .pwd_open_clr(pwd_open_clr),
    .pwd_open(pwd_open), .busy(busy), .resp_valid(resp_valid), .resp_ready(resp_ready),
    .resp_kind(resp_kind), .resp_data(resp_data));
  tpa_reader_model tpa_reader_model_inst (.clk(clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_last(rx_last), .resp_valid(resp_valid), .resp_ready(resp_ready));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // answer is compared just before the edge that takes it, while it stands
  task automatic answer(input logic [1:0] ek, input logic [63:0] ed, input int stall);
    fork
      tpa_reader_model_inst.take(stall);
      begin
        wait (resp_ready === 1'b1);
        `CHK("resp_valid", 1, resp_valid);
        `CHK("resp_kind", ek, resp_kind);
        `CHK("resp_data", ed, resp_data);
      end
    join
  endtask
  task automatic cmd(input logic [3:0] op, input logic [7:0] a, input logic [63:0] dt,
                     input logic [1:0] ek, input logic [63:0] ed, input int stall);
    tpa_reader_model_inst.send(op, slot, a, dt, 1'b0);
    answer(ek, ed, stall);
  endtask
  // a frame that must stay unanswered
  task automatic quiet(input logic [3:0] op, input logic [3:0] sl, input logic bad);
    tpa_reader_model_inst.send(op, sl, 8'h01, 64'h0, bad);
    repeat (30) @(posedge clk);
    #1;
    `CHK("resp_valid", 0, resp_valid);
  endtask
  task automatic conclude();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // main sequence of commands
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    `CHK("pwd_open", 0, pwd_open);
    cmd(4'h4, 8'h00, 64'h0, 2'h3, 64'h0, 0);
    cmd(4'h4, 8'h04, 64'h0, 2'h2, 64'h0, 3);
    cmd(4'h3, 8'h05, D, 2'h2, 64'h0, 0);
    cmd(4'h2, 8'h00, 64'h0000_0041_0000_0000, 2'h2, 64'h0, 0);
    pwd_open_set = 1'b1;
    @(posedge clk);
    #1;
    pwd_open_set = 1'b0;
    `CHK("pwd_open", 1, pwd_open);
    cmd(4'h3, 8'he5, D, 2'h1, 64'h0, 0);
    cmd(4'h4, 8'h05, 64'h0, 2'h3, D, 2);
    cmd(4'h4, 8'h03, 64'h0, 2'h2, 64'h0, 0);
    cmd(4'h3, 8'h00, D, 2'h2, 64'h0, 0);
    cmd(4'h3, 8'h02, D, 2'h2, 64'h0, 0);
    cmd(4'h2, 8'h1f, 64'h0000_0041_ffff_ffff, 2'h1, 64'h0, 0);
    cmd(4'h4, 8'h00, 64'h0, 2'h3, 64'h0000_0020_0000_0000, 0);
    cmd(4'h3, 8'h05, ~D, 2'h2, 64'h0, 0);
    cmd(4'h4, 8'h05, 64'h0, 2'h3, D, 0);
    // second frame piles up in the fifo while the first answer is held
    fork
      cmd(4'h4, 8'h05, 64'h0, 2'h3, D, 25);
      begin
        repeat (14) @(posedge clk);
        #1;
        tpa_reader_model_inst.send(4'h4, slot, 8'h05, 64'h0, 1'b0);
      end
      begin
        repeat (30) @(posedge clk);
        #1;
        `CHK("rx_ready", 0, rx_ready);
      end
    join
    answer(2'h3, D, 0);
    quiet(4'h4, slot, 1'b1);
    quiet(4'h6, slot, 1'b0);
    quiet(4'h4, 4'h2, 1'b0);
    tag_active = 1'b0;
    quiet(4'h4, slot, 1'b0);
    tag_active = 1'b1;
    pwd_open_clr = 1'b1;
    @(posedge clk);
    #1;
    pwd_open_clr = 1'b0;
    `CHK("pwd_open", 0, pwd_open);
    cmd(4'h4, 8'h05, 64'h0, 2'h2, 64'h0, 0);
    cmd(4'h4, 8'h01, 64'h0, 2'h3, 64'h0, 0);
    conclude();
  end
  // cuts a hang short
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule // tag_page_access_commands_bench
`undef CHK
`default_nettype wire
